// ### hdl/touch_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "touch_i2c_params.svh"
module touch_i2c_slave (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    i2c_link_if.device link,
    input wire logic addr_sel_i,
    input wire logic [7:0] rd_data_i,
    output logic [15:0] rd_addr_o,
    output logic wr_en_o,
    output logic [15:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic busy_o
);

    touch_i2c_pkg::dev_reg_type s_q;
    touch_i2c_pkg::dev_reg_type s_d;

    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] own_addr;

    // Edges taken against the previous sample; pins are synchronous
    assign rise = link.scl & ~s_q.scl_p;
    assign fall = ~link.scl & s_q.scl_p;
    assign start_seen = s_q.scl_p & link.scl & s_q.sda_p & ~link.sda;
    assign stop_seen = s_q.scl_p & link.scl & ~s_q.sda_p & link.sda;
    assign own_addr = s_q.addr_sel ? `ADDR_PAIR_B : `ADDR_PAIR_A;

    always_comb
    begin
        s_d = s_q;
        s_d.wr_en = 1'b0;
        s_d.scl_p = link.scl;
        s_d.sda_p = link.sda;

        // Strap caught once, on the first edge after reset release
        if (!s_q.strapped)
        begin
            s_d.strapped = 1'b1;
            s_d.addr_sel = addr_sel_i;
        end

        // The slave only reacts to host-made starts; it never drives the clock
        if (start_seen)
        begin
            s_d.st = touch_i2c_pkg::ST_ADDR;
            s_d.bit_cnt = 4'h0;
            s_d.sda_oe = 1'b0;
            s_d.byte_idx = 2'h0;
        end
        else if (stop_seen)
        begin
            s_d.st = touch_i2c_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
        end
        else
        begin
            case (s_q.st)
                touch_i2c_pkg::ST_IDLE:
                begin
                    s_d.sda_oe = 1'b0;
                end

                touch_i2c_pkg::ST_ADDR:
                begin
                    if (rise)
                    begin
                        s_d.shift = {s_q.shift[6:0], link.sda};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end
                    else if (fall && s_q.bit_cnt == `BYTE_BITS)
                    begin
                        // Direction bit excluded: even and odd share one pair
                        if (s_q.shift[7:1] == own_addr[7:1])
                        begin
                            s_d.sda_oe = 1'b1;
                            s_d.rw = s_q.shift[0];
                            s_d.st = touch_i2c_pkg::ST_ACK;
                            if (!s_q.shift[0])
                            begin
                                s_d.byte_idx = `BYTE_IDX_REG_H;
                            end
                        end
                        else
                        begin
                            s_d.st = touch_i2c_pkg::ST_IDLE;
                        end
                    end
                end

                touch_i2c_pkg::ST_RX:
                begin
                    if (rise)
                    begin
                        s_d.shift = {s_q.shift[6:0], link.sda};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end
                    else if (fall && s_q.bit_cnt == `BYTE_BITS)
                    begin
                        s_d.sda_oe = 1'b1;
                        s_d.st = touch_i2c_pkg::ST_ACK;
                        case (s_q.byte_idx)
                            `BYTE_IDX_REG_H:
                            begin
                                s_d.ptr[15:8] = s_q.shift;
                                s_d.byte_idx = `BYTE_IDX_REG_L;
                            end
                            `BYTE_IDX_REG_L:
                            begin
                                s_d.ptr[7:0] = s_q.shift;
                                s_d.byte_idx = `BYTE_IDX_DATA;
                            end
                            `BYTE_IDX_DATA:
                            begin
                                s_d.wr_en = 1'b1;
                                s_d.wr_addr = s_q.ptr;
                                s_d.wr_data = s_q.shift;
                                s_d.ptr = s_q.ptr + 16'h0001;
                            end
                            default:
                            begin
                                s_d.byte_idx = `BYTE_IDX_REG_H;
                            end
                        endcase
                    end
                end

                touch_i2c_pkg::ST_ACK:
                begin
                    // Ninth clock ends at this fall; hand the line over
                    if (fall)
                    begin
                        s_d.bit_cnt = 4'h0;
                        if (s_q.rw)
                        begin
                            s_d.st = touch_i2c_pkg::ST_TX;
                            s_d.shift = rd_data_i;
                            s_d.sda_oe = ~rd_data_i[7];
                        end
                        else
                        begin
                            s_d.st = touch_i2c_pkg::ST_RX;
                            s_d.sda_oe = 1'b0;
                        end
                    end
                end

                touch_i2c_pkg::ST_TX:
                begin
                    if (rise)
                    begin
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end
                    else if (fall)
                    begin
                        // Bits change only after a fall, so they hold through high
                        if (s_q.bit_cnt == `BYTE_BITS)
                        begin
                            s_d.sda_oe = 1'b0;
                            s_d.st = touch_i2c_pkg::ST_TACK;
                        end
                        else
                        begin
                            s_d.shift = {s_q.shift[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.shift[6];
                        end
                    end
                end

                touch_i2c_pkg::ST_TACK:
                begin
                    if (rise)
                    begin
                        s_d.ptr = s_q.ptr + 16'h0001;
                        s_d.more = ~link.sda;
                    end
                    else if (fall)
                    begin
                        s_d.bit_cnt = 4'h0;
                        if (s_q.more)
                        begin
                            s_d.st = touch_i2c_pkg::ST_TX;
                            s_d.shift = rd_data_i;
                            s_d.sda_oe = ~rd_data_i[7];
                        end
                        else
                        begin
                            // Line stays released until stop or start
                            s_d.st = touch_i2c_pkg::ST_IDLE;
                            s_d.sda_oe = 1'b0;
                        end
                    end
                end

                default:
                begin
                    s_d.st = touch_i2c_pkg::ST_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end

        s_d.busy = (s_d.st != touch_i2c_pkg::ST_IDLE);
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= '0;
            s_q.st <= touch_i2c_pkg::ST_IDLE;
            s_q.scl_p <= 1'b1;
            s_q.sda_p <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.dev_sda_oe = s_q.sda_oe;
    // Open drain: only ever pulls low
    assign link.dev_sda_out = 1'b0;
    assign rd_addr_o = s_q.ptr;
    assign wr_en_o = s_q.wr_en;
    assign wr_addr_o = s_q.wr_addr;
    assign wr_data_o = s_q.wr_data;
    assign busy_o = s_q.busy;

endmodule
`default_nettype wire

// ### hdl/touch_i2c_params.svh
// Overview of operation
// - Device is slave only, never starts transfers.
// - Host keeps clock at or below 400 kbps.
// - Device answers one of two strapped address pairs.
// - Start is data falling while clock high.
// - Matching address byte acknowledged during ninth clock.
// - Unmatched address: no acknowledge, idle until start.
// - Each byte is eight bits plus acknowledge.
// - Data sampled, held stable, while clock high.
// - Stop is data rising while clock high; idle.
// - Write: address, 16-bit pointer, then stored data bytes.
// - Pointer increments after every written data byte.
// - Read: write pointer, repeated start, read address.
// - Device returns bytes while host keeps acknowledging.
// - Host acknowledges each read byte, last gets NACK.
`ifndef TOUCH_I2C_PARAMS_SVH
`define TOUCH_I2C_PARAMS_SVH
`define ADDR_PAIR_A 8'hba
`define ADDR_PAIR_B 8'h28
`define BYTE_BITS 4'h8
`define BYTE_IDX_REG_H 2'h1
`define BYTE_IDX_REG_L 2'h2
`define BYTE_IDX_DATA 2'h3
`define CLK_PERIOD_NS 5
`define T_LOW_NS 1300
`define T_HIGH_NS 1200
`define LOW_CYC ((`T_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HIGH_CYC ((`T_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_HALF_CYC ((`LOW_CYC + 1) / 2)
`define HOST_LAST_STEP 3'h4
`endif

// ### hdl/touch_i2c_pkg.sv
package touch_i2c_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_RX = 3'h2,
        ST_ACK = 3'h3,
        ST_TX = 3'h4,
        ST_TACK = 3'h5
    } dev_state_type;

    typedef struct packed {
        dev_state_type st;
        logic scl_p;
        logic sda_p;
        logic strapped;
        logic addr_sel;
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic rw;
        logic more;
        logic [7:0] shift;
        logic [15:0] ptr;
        logic sda_oe;
        logic wr_en;
        logic [15:0] wr_addr;
        logic [7:0] wr_data;
        logic busy;
    } dev_reg_type;

    typedef enum logic [1:0] {
        CMD_START = 2'h0,
        CMD_STOP = 2'h1,
        CMD_WRITE = 2'h2,
        CMD_READ = 2'h3
    } cmd_type;

    typedef struct packed {
        logic busy;
        logic ready;
        cmd_type op;
        logic [2:0] step;
        logic [8:0] timer;
        logic [3:0] bit_cnt;
        logic [8:0] tx;
        logic [8:0] rx;
        logic scl_oe;
        logic sda_oe;
        logic done;
        logic [7:0] rdata;
        logic ack;
    } host_reg_type;

endpackage

// ### hdl/i2c_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
    logic host_scl_oe;
    logic host_scl_out;
    logic host_sda_oe;
    logic host_sda_out;
    logic dev_sda_oe;
    logic dev_sda_out;
    logic scl;
    logic sda;

    // Open drain with pull-up: any enabled low driver wins
    assign scl = ~(host_scl_oe & ~host_scl_out);
    assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

    modport host (
        output host_scl_oe,
        output host_scl_out,
        output host_sda_oe,
        output host_sda_out,
        input scl,
        input sda
    );

    modport device (
        output dev_sda_oe,
        output dev_sda_out,
        input scl,
        input sda
    );
endinterface
`default_nettype wire

// ### hdl/touch_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "touch_i2c_params.svh"
module touch_i2c_host (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    i2c_link_if.host link,
    input wire logic cmd_valid_i,
    input wire touch_i2c_pkg::cmd_type cmd_i,
    input wire logic [7:0] wdata_i,
    input wire logic nack_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic ack_o
);

    localparam logic [8:0] LOW_HALF = 9'(`LOW_HALF_CYC);
    localparam logic [8:0] HIGH_LEN = 9'(`HIGH_CYC);

    touch_i2c_pkg::host_reg_type s_q;
    touch_i2c_pkg::host_reg_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy)
        begin
            if (cmd_valid_i)
            begin
                s_d.busy = 1'b1;
                s_d.op = cmd_i;
                s_d.step = 3'h0;
                s_d.timer = 9'h000;
                s_d.bit_cnt = 4'h0;
                // Read byte: release 8 bits, then drive ACK or NACK
                s_d.tx = (cmd_i == touch_i2c_pkg::CMD_WRITE) ? {wdata_i, 1'b1}
                                                             : {8'hff, nack_i};
            end
        end
        else if (s_q.timer != 9'h000)
        begin
            s_d.timer = s_q.timer - 9'h001;
        end
        else if (s_q.step == `HOST_LAST_STEP)
        begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.rdata = s_q.rx[8:1];
            s_d.ack = ~s_q.rx[0];
        end
        else
        begin
            s_d.step = s_q.step + 3'h1;
            case (s_q.op)
                touch_i2c_pkg::CMD_START:
                begin
                    // Release data first so a repeated start has a high level to fall from
                    case (s_q.step)
                        3'h0:
                        begin
                            s_d.sda_oe = 1'b0;
                            s_d.timer = LOW_HALF;
                        end
                        3'h1:
                        begin
                            s_d.scl_oe = 1'b0;
                            s_d.timer = HIGH_LEN;
                        end
                        3'h2:
                        begin
                            s_d.sda_oe = 1'b1;
                            s_d.timer = HIGH_LEN;
                        end
                        default:
                        begin
                            s_d.scl_oe = 1'b1;
                            s_d.timer = LOW_HALF;
                        end
                    endcase
                end
                touch_i2c_pkg::CMD_STOP:
                begin
                    case (s_q.step)
                        3'h0:
                        begin
                            s_d.sda_oe = 1'b1;
                            s_d.timer = LOW_HALF;
                        end
                        3'h1:
                        begin
                            s_d.scl_oe = 1'b0;
                            s_d.timer = HIGH_LEN;
                        end
                        3'h2:
                        begin
                            s_d.sda_oe = 1'b0;
                            s_d.timer = HIGH_LEN;
                        end
                        default:
                        begin
                            s_d.timer = 9'h001;
                        end
                    endcase
                end
                default:
                begin
                    // Low 1.3 us, high 1.2 us: 400 kbps at most
                    case (s_q.step)
                        3'h0:
                        begin
                            s_d.sda_oe = ~s_q.tx[8];
                            s_d.timer = LOW_HALF;
                        end
                        3'h1:
                        begin
                            s_d.scl_oe = 1'b0;
                            s_d.timer = HIGH_LEN;
                        end
                        default:
                        begin
                            s_d.rx = {s_q.rx[7:0], link.sda};
                            s_d.scl_oe = 1'b1;
                            s_d.tx = {s_q.tx[7:0], 1'b1};
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                            s_d.timer = LOW_HALF;
                            s_d.step = (s_q.bit_cnt == `BYTE_BITS) ? `HOST_LAST_STEP
                                                                   : 3'h0;
                        end
                    endcase
                end
            endcase
        end
        s_d.ready = ~s_d.busy;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= '0;
            s_q.ready <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.host_scl_oe = s_q.scl_oe;
    assign link.host_scl_out = 1'b0;
    assign link.host_sda_oe = s_q.sda_oe;
    assign link.host_sda_out = 1'b0;
    assign cmd_ready_o = s_q.ready;
    assign done_o = s_q.done;
    assign rdata_o = s_q.rdata;
    assign ack_o = s_q.ack;

endmodule
`default_nettype wire

// ### verif/touch_i2c_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module touch_i2c_asserts (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic addr_sel_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe
);
    logic scl_q, sda_q, first_q, hit_q, rw_q, nacked_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [8:0] low_q;
    logic rise, start, stop, match;

    assign rise = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    assign stop = scl && scl_q && !sda_q && sda;
    assign match = sh_q[7:1] == (addr_sel_i ? 7'h14 : 7'h5d);

    // Tracks the byte framing seen on the wire, independent of the slave
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            {scl_q, sda_q, first_q, hit_q, rw_q, nacked_q, cnt_q, sh_q, low_q}
                <= {2'b11, 25'h0};
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            // Saturating count of clock-low cycles, for the bit rate check
            low_q <= scl ? 9'h000 : low_q + {8'h00, low_q != 9'h1ff};
            if (start || stop)
            begin
                cnt_q <= 4'h0;
                first_q <= start;
                hit_q <= 1'b0;
                nacked_q <= 1'b0;
            end
            else if (rise)
            begin
                sh_q <= {sh_q[6:0], sda};
                cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == 4'h8 && first_q)
                begin
                    first_q <= 1'b0;
                    hit_q <= match;
                    rw_q <= sh_q[0];
                end
                if (cnt_q == 4'h8 && !first_q && hit_q && rw_q && sda)
                    nacked_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_addr_quiet: assert property (rise && first_q && cnt_q != 4'h8 |-> !dev_sda_oe)
        else $error("slave drove data during address bits");
    a_addr_ack: assert property (rise && first_q && cnt_q == 4'h8 |-> dev_sda_oe == match)
        else $error("address acknowledge wrong");
    a_unmatched_idle: assert property (rise && !first_q && !hit_q |-> !dev_sda_oe)
        else $error("unaddressed slave drove data");
    a_write_ack: assert property (rise && !first_q && hit_q && !rw_q
        |-> dev_sda_oe == (cnt_q == 4'h8))
        else $error("write byte acknowledge wrong");
    a_read_release: assert property (rise && !first_q && hit_q && rw_q && cnt_q == 4'h8
        |-> !dev_sda_oe)
        else $error("slave held data in host ack slot");
    a_nack_release: assert property (nacked_q |-> !dev_sda_oe)
        else $error("slave drove after host nack");
    a_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("slave data changed while clock high");
    a_drive_on_low: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("slave started driving outside clock low");
    a_stop_idle: assert property (stop |=> !dev_sda_oe [*8])
        else $error("slave active after stop");
    a_start_rx: assert property (start |=> !dev_sda_oe [*8])
        else $error("slave drove right after start");
    a_scl_low_min: assert property (rise |-> low_q >= 9'h104)
        else $error("clock low phase too short for rate limit");
endmodule
`default_nettype wire

// ### verif/touch_ctrl_i2c_slave_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module touch_ctrl_i2c_slave_port_tb_top;
    logic mclk_i = 1'b0;
    logic rst_b_i, addr_sel_i, wr_en_o, busy_o, cmd_valid_i, nack_i;
    logic cmd_ready_o, done_o, ack_o;
    logic [7:0] rd_data_i, wr_data_o, wdata_i, rdata_o, d0, d1;
    logic [15:0] rd_addr_o, wr_addr_o, p;
    touch_i2c_pkg::cmd_type cmd_i;
    logic [31:0] seed = 32'h17;
    logic [9:0] e;
    logic [9:0] exp_q[$];
    logic [23:0] wr_q[$];
    int bad_count = 0;
    int cmp_count = 0;

    always #2.5 mclk_i = ~mclk_i;

    i2c_link_if i2c_link_if_i ();
    touch_i2c_slave touch_i2c_slave_i (.mclk_i, .rst_b_i, .link(i2c_link_if_i), .addr_sel_i,
        .rd_data_i, .rd_addr_o, .wr_en_o, .wr_addr_o, .wr_data_o, .busy_o);
    touch_i2c_host touch_i2c_host_i (.mclk_i, .rst_b_i, .link(i2c_link_if_i), .cmd_valid_i,
        .cmd_i, .wdata_i, .nack_i, .cmd_ready_o, .done_o, .rdata_o, .ack_o);
    touch_i2c_asserts touch_i2c_asserts_i (.mclk_i, .rst_b_i, .addr_sel_i,
        .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda), .dev_sda_oe(i2c_link_if_i.dev_sda_oe));

    // Register contents are a pure function of the address, so reads are predictable
    function automatic logic [7:0] fn(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    function automatic logic [31:0] nxt(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    assign rd_data_i = fn(rd_addr_o);

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic do_reset();
        rst_b_i = 1'b0;
        repeat (6) @(negedge mclk_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge mclk_i);
    endtask

    task automatic cmd(input touch_i2c_pkg::cmd_type c, input logic [7:0] d, input logic n,
        input logic [9:0] x);
        int i;
        i = 0;
        while (cmd_ready_o !== 1'b1 && i < 20)
        begin
            @(negedge mclk_i);
            i++;
        end
        exp_q.push_back(x);
        cmd_valid_i = 1'b1;
        cmd_i = c;
        wdata_i = d;
        nack_i = n;
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        i = 0;
        while (done_o !== 1'b1 && i < 6000)
        begin
            @(negedge mclk_i);
            i++;
        end
        if (done_o !== 1'b1)
        begin
            // A command that never ends leaves nothing to compare; stop here
            bad_count++;
            summarize();
        end
        @(negedge mclk_i);
    endtask

    task automatic st();
        cmd(touch_i2c_pkg::CMD_START, 8'h00, 1'b0, 10'h0);
    endtask

    task automatic sp();
        cmd(touch_i2c_pkg::CMD_STOP, 8'h00, 1'b0, 10'h0);
    endtask

    task automatic wr(input logic [7:0] d, input logic a);
        cmd(touch_i2c_pkg::CMD_WRITE, d, 1'b0, {2'h1, 7'h0, a});
    endtask

    task automatic rd(input logic n, input logic [7:0] v);
        cmd(touch_i2c_pkg::CMD_READ, 8'h00, n, {2'h2, v});
    endtask

    // Result watcher: every completed write or read command and every register write is checked in order
    always @(negedge mclk_i)
    begin
        if (wr_en_o === 1'b1)
            check({wr_addr_o, wr_data_o}, wr_q.pop_front());
        if (done_o === 1'b1)
        begin
            e = exp_q.pop_front();
            if (e[9:8] == 2'h1)
                check(24'(ack_o), 24'(e[0]));
            else if (e[9:8] == 2'h2)
                check(24'(rdata_o), 24'(e[7:0]));
        end
    end

    initial
    begin
        repeat (90000) @(posedge mclk_i);
        bad_count++;
        summarize();
    end

    initial
    begin
        cmd_valid_i = 1'b0;
        cmd_i = touch_i2c_pkg::CMD_START;
        wdata_i = 8'h00;
        nack_i = 1'b0;
        addr_sel_i = 1'b0;
        do_reset();
        // Burst write across a low-byte carry of the pointer
        seed = nxt(seed);
        p = {seed[15:8], 8'hff};
        seed = nxt(seed);
        d0 = seed[7:0];
        d1 = seed[15:8];
        wr_q.push_back({p, d0});
        wr_q.push_back({p + 16'h1, d1});
        st();
        wr(8'hba, 1'b1);
        wr(p[15:8], 1'b1);
        wr(p[7:0], 1'b1);
        wr(d0, 1'b1);
        wr(d1, 1'b1);
        sp();
        check(24'(busy_o), 24'h0);
        check(24'(rd_addr_o), {8'h00, p + 16'h2});
        // Pointer set, repeated start, burst read ending in nack
        seed = nxt(seed);
        p = seed[15:0];
        st();
        wr(8'hba, 1'b1);
        wr(p[15:8], 1'b1);
        wr(p[7:0], 1'b1);
        st();
        wr(8'hbb, 1'b1);
        rd(1'b0, fn(p));
        rd(1'b1, fn(p + 16'h1));
        sp();
        check(24'(rd_addr_o), {8'h00, p + 16'h2});
        // Other address pair: old pair refused, aborted transfer, then read
        addr_sel_i = 1'b1;
        do_reset();
        st();
        wr(8'hba, 1'b0);
        check(24'(busy_o), 24'h0);
        st();
        wr(8'h28, 1'b1);
        st();
        wr(8'h29, 1'b1);
        rd(1'b1, fn(16'h0));
        sp();
        check(24'(rd_addr_o), 24'h1);
        check(24'(wr_q.size()), 24'h0);
        check(24'(exp_q.size()), 24'h0);
        summarize();
    end
endmodule
`default_nettype wire
